// ==== hbs_brake_seq.sv ====
// hbs_brake_seq: holding brake sequencer with pwm brake drive
// Function
// R1: brake closed unless auto and operation enabled; code also opens it from manual bit 0 and through the stop delay
// R2: submode bit 2 set selects automatic sequencing
// R3: bit 2 clear: brake follows output bit 0
// R4: enable: current, delay 3, release, delay 4
// R5: leave: stop, delay 1, engage, delay 2, off
// R6: released brake driven as pwm waveform
// R7: frequency from entry 5, above 2000 refused
// R8: duty from entry 6, range 2 to 100
// R9: duty 100 holds output solid on
// R10: waveform and inverse selectable for outputs
// R11: setting changes apply at period boundary
// R12: manual one releases, zero engages brake
// assumes the power state machine and routing logic share i_clk
`timescale 1ns/1ns
module hbs_brake_seq #(
	parameter int unsigned CLK_HZ = hbs_pkg::CLK_HZ,
	parameter int unsigned MS_CYCLES = hbs_pkg::MS_CYCLES,
	parameter int NOUT = 2
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic [15:0] i_drive_submode_select,
	input wire logic [31:0] i_digital_output_bits,
	input wire logic i_op_enable_req,
	input wire logic i_motor_standstill,
	input wire logic [15:0] i_delay_stop_ms,
	input wire logic [15:0] i_delay_off_ms,
	input wire logic [15:0] i_delay_rel_ms,
	input wire logic [15:0] i_delay_run_ms,
	input wire logic [15:0] i_freq_hz,
	input wire logic [6:0] i_duty_pct,
	input wire logic [NOUT*16-1:0] i_out_route,
	output logic o_motor_current_on,
	output logic o_motor_stop_req,
	output logic o_travel_enable,
	output logic o_brake_released,
	output logic o_brake_drive,
	output logic [NOUT-1:0] o_wave_route,
	output logic [NOUT-1:0] o_wave_route_sel
);
	// refuse settings the counters cannot serve
	initial begin
		if (NOUT < 1 || NOUT > 16) $error("NOUT out of range");
		if (CLK_HZ < 32'(hbs_pkg::FREQ_MAX_HZ)) $error("CLK_HZ below top waveform rate");
		if (MS_CYCLES < 1) $error("MS_CYCLES must be at least 1");
	end

	// sequencer state and delay counter
	hbs_pkg::hbs_state_t state_r;
	hbs_pkg::hbs_state_t state_nxt;
	logic [31:0] ms_cnt_r;
	logic [15:0] dly_r;
	logic [15:0] dly_nxt;
	logic load_dly;
	logic drive_r;
	logic [NOUT-1:0] route_r;
	logic [NOUT-1:0] route_sel_r;
	logic wave;
	wire logic auto_mode;
	wire logic manual_on;
	wire logic ms_tick;
	wire logic dly_done;
	wire logic released;
	wire logic brake_on;
	// delay counter controls and per-output routing decode
	wire logic [15:0] dly_load;
	wire logic dly_hold;
	wire logic dly_count;
	wire logic [NOUT-1:0] sel_wave;
	wire logic [NOUT-1:0] sel_inv;

	// millisecond-in-cycles conversion is shared by every delay entry
	function automatic logic [15:0] ms_sel(input hbs_pkg::hbs_state_t st,
		input logic [15:0] a, input logic [15:0] b, input logic [15:0] c,
		input logic [15:0] d);
		case (st)
			hbs_pkg::HBS_WAIT_REL: ms_sel = a;
			hbs_pkg::HBS_WAIT_RUN: ms_sel = b;
			hbs_pkg::HBS_WAIT_ENG: ms_sel = c;
			hbs_pkg::HBS_WAIT_OFF: ms_sel = d;
			default: ms_sel = 16'h0000;
		endcase
	endfunction : ms_sel

	// routing source code lives in the upper byte of a routing word
	function automatic logic [7:0] src_of(input logic [15:0] word);
		src_of = word[15:8];
	endfunction : src_of

	////////////////////////////////////////////////////////////////////////
	// mode decode
	assign auto_mode = i_drive_submode_select[hbs_pkg::AUTO_BIT]; // R2
	assign manual_on = i_digital_output_bits[hbs_pkg::MANUAL_BIT]; // R3
	assign ms_tick = (ms_cnt_r == MS_CYCLES - 1);
	assign dly_done = (dly_r == 16'h0000);

	////////////////////////////////////////////////////////////////////////
	// sequencer next state; leaving enable aborts any power-up wait
	always_comb begin
		state_nxt = state_r;
		load_dly = 1'b0;
		case (state_r)
			hbs_pkg::HBS_ENGAGED: begin
				// a new start waits for any wind-down to finish
				if (auto_mode && i_op_enable_req) begin
					state_nxt = hbs_pkg::HBS_WAIT_REL; // R4
					load_dly = 1'b1;
				end
			end
			hbs_pkg::HBS_WAIT_REL: begin
				if (!auto_mode || !i_op_enable_req) begin
					state_nxt = hbs_pkg::HBS_WAIT_OFF; // brake still closed
					load_dly = 1'b1;
				end else if (dly_done) begin
					state_nxt = hbs_pkg::HBS_WAIT_RUN; // R4
					load_dly = 1'b1;
				end
			end
			hbs_pkg::HBS_WAIT_RUN: begin
				if (!auto_mode || !i_op_enable_req) begin
					state_nxt = hbs_pkg::HBS_WAIT_ENG; // R5
					load_dly = 1'b1;
				end else if (dly_done) begin
					state_nxt = hbs_pkg::HBS_RUNNING; // R4
				end
			end
			hbs_pkg::HBS_RUNNING: begin
				if (!auto_mode || !i_op_enable_req) begin
					state_nxt = hbs_pkg::HBS_WAIT_ENG; // R5
					load_dly = 1'b1;
				end
			end
			hbs_pkg::HBS_WAIT_ENG: begin
				// delay counts only once the motor is at standstill
				if (dly_done && i_motor_standstill) begin
					state_nxt = hbs_pkg::HBS_WAIT_OFF; // R5
					load_dly = 1'b1;
				end
			end
			hbs_pkg::HBS_WAIT_OFF: begin
				// current stays on until the off delay ends
				if (dly_done)
					state_nxt = hbs_pkg::HBS_ENGAGED; // R5
			end
			default: state_nxt = hbs_pkg::HBS_ENGAGED;
		endcase
	end

	// the stop delay only runs once the motor reports standstill
	assign dly_load = ms_sel(state_nxt, i_delay_rel_ms, i_delay_run_ms,
		i_delay_stop_ms, i_delay_off_ms);
	assign dly_hold = (state_r == hbs_pkg::HBS_WAIT_ENG) && !i_motor_standstill; // R5
	assign dly_count = ms_tick && !dly_done && !dly_hold;
	assign dly_nxt = load_dly ? dly_load : (dly_count ? dly_r - 16'h0001 : dly_r);

	////////////////////////////////////////////////////////////////////////
	// state, delay and millisecond divider registers
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state_r <= hbs_pkg::HBS_ENGAGED;
			ms_cnt_r <= '0;
			dly_r <= 16'h0000;
		end else begin
			state_r <= state_nxt;
			// divider restarts on every load so each delay starts clean
			ms_cnt_r <= (ms_tick || load_dly) ? '0 : ms_cnt_r + 32'h1;
			dly_r <= dly_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// brake release decision
	// brake stays open through the stop delay, closing only after it
	assign released = (state_r == hbs_pkg::HBS_WAIT_RUN) ||
		(state_r == hbs_pkg::HBS_RUNNING) ||
		(state_r == hbs_pkg::HBS_WAIT_ENG); // R1 R5
	// manual one energises the coil
	assign brake_on = auto_mode ? released : manual_on; // R12

	// waveform runs free; the sequencer only gates it onto the coil
	hbs_wave #(
		.CLK_HZ(CLK_HZ)
	) u_wave (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_freq_hz(i_freq_hz),
		.i_duty_pct(i_duty_pct),
		.o_wave(wave)
	);

	////////////////////////////////////////////////////////////////////////
	// routing decode per output word; inverse is an xor on the shared waveform
	for (genvar g = 0; g < NOUT; g++) begin : g_route
		assign sel_wave[g] = (src_of(i_out_route[g*16 +: 16]) == hbs_pkg::SRC_WAVE);
		assign sel_inv[g] = (src_of(i_out_route[g*16 +: 16]) == hbs_pkg::SRC_WAVE_INV);
	end

	////////////////////////////////////////////////////////////////////////
	// output registers; one register stage matches the brake drive path
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			drive_r <= 1'b0;
			route_r <= '0;
			route_sel_r <= '0;
		end else begin
			// coil sees the waveform only while the brake is to be open
			drive_r <= brake_on & wave; // R6
			route_sel_r <= sel_wave | sel_inv; // R10
			route_r <= sel_inv ^ {NOUT{wave}}; // R10
		end
	end

	////////////////////////////////////////////////////////////////////////
	// current, stop and travel outputs decode the state register; levels, not pulses
	assign o_brake_drive = drive_r;
	assign o_wave_route = route_r;
	assign o_wave_route_sel = route_sel_r;
	assign o_brake_released = brake_on;
	assign o_motor_current_on = (state_r != hbs_pkg::HBS_ENGAGED); // R4
	assign o_motor_stop_req = (state_r == hbs_pkg::HBS_WAIT_ENG); // R5
	assign o_travel_enable = (state_r == hbs_pkg::HBS_RUNNING); // R4
endmodule : hbs_brake_seq

// ==== hbs_pkg.sv ====
// hbs_pkg: constants for the holding brake sequencer and its waveform generator
// assumes a 250 MHz system clock; no bus, all settings arrive as plain ports
package hbs_pkg;
	// clock rate in hertz
	localparam int unsigned CLK_HZ = 250000000;
	// submode select bit that enables automatic brake control
	localparam int AUTO_BIT = 2;
	// digital output bit that drives the brake in manual mode
	localparam int MANUAL_BIT = 0;
	// waveform limits
	localparam logic [15:0] FREQ_MAX_HZ = 16'h07D0;
	localparam logic [6:0] DUTY_MIN = 7'h02;
	localparam logic [6:0] DUTY_FULL = 7'h64;
	// defaults used when a setting is out of range
	localparam logic [15:0] FREQ_DEF_HZ = 16'h07D0;
	localparam logic [6:0] DUTY_DEF = 7'h64;
	// delay settings count in milliseconds
	localparam int unsigned MS_NS = 1000000;
	localparam int unsigned CLK_NS = 4;
	localparam int unsigned MS_CYCLES = MS_NS / CLK_NS;
	// routing source codes, upper byte of a routing word
	localparam logic [7:0] SRC_WAVE = 8'h10;
	localparam logic [7:0] SRC_WAVE_INV = 8'h11;
	// sequencer states
	typedef enum logic [2:0] {
		HBS_ENGAGED,
		HBS_WAIT_REL,
		HBS_WAIT_RUN,
		HBS_RUNNING,
		HBS_WAIT_ENG,
		HBS_WAIT_OFF
	} hbs_state_t;
endpackage : hbs_pkg

// ==== hbs_wave.sv ====
// hbs_wave: brake pulse-width waveform generator
// assumes settings come from the same clock domain
`timescale 1ns/1ns
module hbs_wave #(
	parameter int unsigned CLK_HZ = hbs_pkg::CLK_HZ
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic [15:0] i_freq_hz,
	input wire logic [6:0] i_duty_pct,
	output logic o_wave
);
	localparam int unsigned PW = 32;
	initial begin
		if (CLK_HZ < 200000) $error("clock too slow for waveform");
	end

	logic [PW-1:0] cnt_r;
	logic [PW-1:0] period_r;
	logic [PW-1:0] high_r;
	logic wave_r;
	wire logic [PW-1:0] per_calc;
	wire logic [PW-1:0] high_calc;
	wire logic [PW-1:0] period_nxt;
	wire logic [PW-1:0] high_nxt;
	wire logic at_end;
	wire logic [15:0] freq_ok;
	wire logic [6:0] duty_ok;

	////////////////////////////////////////////////////////////////////////
	// range screening; rejected values fall back to defaults
	assign freq_ok = (i_freq_hz == 16'h0000 || i_freq_hz > hbs_pkg::FREQ_MAX_HZ) ?
		hbs_pkg::FREQ_DEF_HZ : i_freq_hz; // R7
	assign duty_ok = (i_duty_pct < hbs_pkg::DUTY_MIN || i_duty_pct > hbs_pkg::DUTY_FULL) ?
		hbs_pkg::DUTY_DEF : i_duty_pct; // R8
	assign per_calc = PW'(CLK_HZ / 32'(freq_ok));
	assign high_calc = PW'((64'(per_calc) * 64'(duty_ok)) / 64'd100);
	assign at_end = (cnt_r >= period_r - PW'(1));

	// settings latch only at a period boundary, avoids runt pulses
	assign period_nxt = at_end ? per_calc : period_r; // R11
	assign high_nxt = at_end ? high_calc : high_r; // R11

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			cnt_r <= '0;
			period_r <= PW'(1);
			high_r <= PW'(1);
			wave_r <= 1'b0;
		end else begin
			cnt_r <= at_end ? '0 : cnt_r + PW'(1);
			period_r <= period_nxt;
			high_r <= high_nxt;
			// full duty keeps the output solid high
			wave_r <= (cnt_r < high_r) || (high_r >= period_r); // R9
		end
	end
	assign o_wave = wave_r;
endmodule : hbs_wave

// ==== hbs_brake_seq_sva.sv ====
// hbs_brake_seq_sva: port assertions for the brake sequencer
// assumes one clock, bound from the testbench
`timescale 1ns/1ns
module hbs_brake_seq_sva #(
	parameter int unsigned MS_CYCLES = 10
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic [15:0] i_drive_submode_select,
	input wire logic [31:0] i_digital_output_bits,
	input wire logic i_op_enable_req,
	input wire logic [15:0] i_delay_rel_ms,
	input wire logic [31:0] i_out_route,
	input wire logic o_motor_current_on,
	input wire logic o_travel_enable,
	input wire logic o_brake_released,
	input wire logic o_brake_drive,
	input wire logic [1:0] o_wave_route,
	input wire logic [1:0] o_wave_route_sel
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	logic auto;
	logic [31:0] wait_r;
	assign auto = i_drive_submode_select[2];
	// powered but braked cycles; release delay is judged on this
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			wait_r <= '0;
		else
			wait_r <= (o_motor_current_on && !o_brake_released) ? wait_r + 1 : '0;
	end
	sequence s_release;
		auto ##0 $rose(o_brake_released);
	endsequence
	sequence s_shutdown;
		auto ##0 $fell(o_motor_current_on);
	endsequence
	AST_HOLD_CLOSED: assert property (
		auto && !o_motor_current_on |-> !o_brake_released) else $error("open unpowered");
	AST_MANUAL: assert property (
		!auto |-> o_brake_released == i_digital_output_bits[0]) else $error("manual");
	AST_REL_DELAY: assert property (
		s_release |-> wait_r >= i_delay_rel_ms * MS_CYCLES
		&& wait_r <= (i_delay_rel_ms + 1) * MS_CYCLES + 2) else $error("release delay");
	AST_TRAVEL: assert property (
		o_travel_enable |-> o_brake_released && o_motor_current_on) else $error("travel");
	AST_DROP: assert property (
		auto && $fell(i_op_enable_req) |=> !o_travel_enable) else $error("drop");
	AST_OFF_LAST: assert property (
		s_shutdown |-> !$past(o_brake_released, 2)) else $error("current off early");
	AST_DRIVE_GATE: assert property (
		o_brake_drive |-> $past(o_brake_released)) else $error("drive while closed");
	AST_ROUTE_SEL: assert property (
		1'b1 |=> o_wave_route_sel[0] == ($past(i_out_route[15:9]) == 7'h08)) else $error("sel");
	AST_ROUTE_INV: assert property (
		(i_out_route == 32'h10001100) [*2] |-> o_wave_route[0] != o_wave_route[1])
		else $error("inverse");
endmodule : hbs_brake_seq_sva

// ==== hbs_coil.sv ====
// hbs_coil: brake coil and motor stand-in, tallies coil drive
// assumes drive and stop request change on i_clk
`timescale 1ns/1ns
module hbs_coil (
	input wire logic i_clk,
	input wire logic i_drive,
	input wire logic i_stop_req,
	output logic o_standstill,
	output int o_on_cnt = 0,
	output int o_rise_cnt = 0
);
	logic last_r = 1'b0;
	logic [1:0] stop_r = 2'b00;
	// motor coasts two cycles before rest, so standstill lags the request
	always @(posedge i_clk) begin
		stop_r <= {stop_r[0], i_stop_req};
		last_r <= i_drive;
		o_on_cnt <= o_on_cnt + int'(i_drive);
		o_rise_cnt <= o_rise_cnt + int'(i_drive && !last_r);
	end
	assign o_standstill = stop_r[1];
endmodule : hbs_coil

// ==== testbench.sv ====
// testbench: sequencer, waveform and routing checks
// assumes CLK_HZ 200000 so 1 kHz is a 200-cycle period, 10 cycles a ms
`timescale 1ns/1ns
module testbench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [15:0] sub = '0;
	logic [31:0] dob = '0;
	logic req = 1'b0;
	logic [6:0] duty = 7'h32;
	logic [15:0] freq = 16'h03E8;
	logic [31:0] route = 32'hFFFFFFFF;
	logic [15:0] dstp = 16'h0001, doff = 16'h0002, drel = 16'h0002, drun = 16'h0001;
	logic stand, cur, stop, trav, rel, drv;
	logic [1:0] wr, ws;
	logic [15:0] tf [7] = '{16'h03E8, 16'h03E8, 16'h07D0, 16'h0BB8, 16'h0000, 16'h03E8, 16'h03E8};
	logic [6:0] td [7] = '{7'h32, 7'h19, 7'h32, 7'h32, 7'h32, 7'h65, 7'h64};
	int ton [7] = '{200, 100, 200, 200, 200, 400, 400};
	int trs [7] = '{2, 2, 4, 4, 4, 0, 0};
	int on_cnt, rise_cnt, errors = 0, comparisons = 0, cyc = 0;
	hbs_brake_seq #(.CLK_HZ(200000), .MS_CYCLES(10), .NOUT(2)) i_dut (.i_clk(clk),
		.i_sys_rst(rst), .i_drive_submode_select(sub), .i_digital_output_bits(dob),
		.i_op_enable_req(req), .i_motor_standstill(stand), .i_delay_stop_ms(dstp),
		.i_delay_off_ms(doff), .i_delay_rel_ms(drel), .i_delay_run_ms(drun),
		.i_freq_hz(freq), .i_duty_pct(duty), .i_out_route(route), .o_motor_current_on(cur),
		.o_motor_stop_req(stop), .o_travel_enable(trav), .o_brake_released(rel),
		.o_brake_drive(drv), .o_wave_route(wr), .o_wave_route_sel(ws));
	hbs_coil i_coil (.i_clk(clk), .i_drive(drv), .i_stop_req(stop), .o_standstill(stand),
		.o_on_cnt(on_cnt), .o_rise_cnt(rise_cnt));
	always #2 clk = ~clk;
	// hang guard; the run needs about 4800 cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			errors++;
			wrap_up();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic wrap_up();
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : wrap_up
	// sample 1 ns after the edge so design updates have landed
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	// bounded wait for current (which=1) or brake to reach a level
	task automatic wait_lvl(input bit which, input logic lvl, output int n);
		n = 0;
		while ((which ? cur : rel) !== lvl && n < 200) begin
			tick(1);
			n++;
		end
	endtask : wait_lvl
	// any 400-cycle window holds whole periods at 1 and 2 kHz
	task automatic measure(input int on_exp, input int rise_exp);
		int a, b;
		a = on_cnt;
		b = rise_cnt;
		tick(400);
		check(on_cnt - a, on_exp);
		check(rise_cnt - b, rise_exp);
	endtask : measure
	////////////////////////////////////////////////////////////////////////
	initial begin
		int n;
		tick(12);
		@(posedge clk) rst <= 1'b0;
		@(posedge clk) dob <= 32'h1;
		tick(1);
		check(rel, 1);
		check(cur, 0);
		@(posedge clk) dob <= 32'h0;
		tick(1);
		check(rel, 0);
		// automatic, not enabled: bit 0 must no longer open it
		@(posedge clk) sub <= 16'h0004;
		@(posedge clk) dob <= 32'h1;
		tick(3);
		check(rel, 0);
		@(posedge clk) req <= 1'b1;
		tick(1);
		check(cur, 1);
		wait_lvl(1'b0, 1'b1, n);
		check(n >= 18 && n <= 32, 1);
		check(trav, 0);
		tick(25);
		check(trav, 1);
		// settings take hold at a period end, so settle before measuring
		foreach (tf[i]) begin
			@(posedge clk) freq <= tf[i];
			duty <= td[i];
			tick(250);
			measure(ton[i], trs[i]);
		end
		@(posedge clk) route <= 32'h10001100;
		tick(2);
		check(ws, 2'b11);
		check(wr, 2'b10);
		@(posedge clk) route <= 32'hFFFFFFFF;
		tick(2);
		check(ws, 2'b00);
		@(posedge clk) req <= 1'b0;
		tick(1);
		check(trav, 0);
		check(stop, 1);
		wait_lvl(1'b0, 1'b0, n);
		check(n >= 10 && cur === 1'b1, 1);
		wait_lvl(1'b1, 1'b0, n);
		check(n >= 18 && n <= 32, 1);
		// second start with a longer release delay
		@(posedge clk) drel <= 16'h0003;
		req <= 1'b1;
		tick(1);
		check(cur, 1);
		wait_lvl(1'b0, 1'b1, n);
		check(n >= 28 && n <= 42, 1);
		wrap_up();
	end
endmodule : testbench
bind hbs_brake_seq hbs_brake_seq_sva #(.MS_CYCLES(MS_CYCLES)) i_sva (.i_clk(i_clk),
	.i_sys_rst(i_sys_rst), .i_drive_submode_select(i_drive_submode_select),
	.i_digital_output_bits(i_digital_output_bits), .i_op_enable_req(i_op_enable_req),
	.i_delay_rel_ms(i_delay_rel_ms), .i_out_route(i_out_route),
	.o_motor_current_on(o_motor_current_on), .o_travel_enable(o_travel_enable),
	.o_brake_released(o_brake_released), .o_brake_drive(o_brake_drive),
	.o_wave_route(o_wave_route), .o_wave_route_sel(o_wave_route_sel));
